//--- sfwc_params.svh
// Purpose: constants shared by both ends of the pattern/status command link
// Assumes: 250 MHz system clock on both ends
// Notes: offsets, bit positions and timing counts live here as macros
`ifndef SFWC_PARAMS_SVH
`define SFWC_PARAMS_SVH

`define SFWC_OP_WRITE_ENABLE 8'h06
`define SFWC_OP_WRITE_DISABLE 8'h04
`define SFWC_OP_VOL_WRITE_ENABLE 8'h50
`define SFWC_OP_CLEAR_STATUS 8'h30
`define SFWC_OP_NV_PAT_PROG 8'h43
`define SFWC_OP_VOL_PAT_WRITE 8'h4a
`define SFWC_OP_PAT_READ 8'h41

`define SFWC_WIP_BIT 0
`define SFWC_WEL_BIT 1
`define SFWC_PERR_BIT 5
`define SFWC_EERR_BIT 6

`define SFWC_PAT_RESET 8'h00
`define SFWC_CLK_NS 4
`define SFWC_MAX_SCK_MHZ 108
`define SFWC_NV_PROG_NS 100000
`define SFWC_NV_PROG_CYC (`SFWC_NV_PROG_NS / `SFWC_CLK_NS)
`define SFWC_SCK_HALF_CYC 10

`define SFWC_REG_CMD 4'h0
`define SFWC_REG_STAT 4'h4
`define SFWC_CMD_OP_LSB 0
`define SFWC_CMD_DATA_LSB 8
`define SFWC_CMD_HAS_DATA 16
`define SFWC_CMD_READ 17
`define SFWC_CMD_QUAD 18
`define SFWC_STAT_BUSY 0
`define SFWC_STAT_RX_LSB 8

`endif

//--- sfwc_pkg.sv
// Purpose: types shared by both ends
// Assumes: nothing
// Notes: gray codes along the normal path
package sfwc_pkg;
  typedef enum logic [2:0] {
    SFWC_H_IDLE = 3'h0,
    SFWC_H_SETUP = 3'h1,
    SFWC_H_LOW = 3'h3,
    SFWC_H_HIGH = 3'h2,
    SFWC_H_HOLD = 3'h6,
    SFWC_H_GAP = 3'h4
  } sfwc_host_st_t;

  typedef enum logic {
    SFWC_D_IDLE = 1'b0,
    SFWC_D_PROG = 1'b1
  } sfwc_dev_st_t;
endpackage

//--- sfwc_if.sv
// Purpose: serial link between controller and flash command logic
// Assumes: spi mode 0, one or four data lines
// Notes: undriven data lines read high, as with a pull-up
`timescale 1ns/1ps
interface sfwc_if;
  logic cs_n;
  logic sck;
  logic [3:0] h_io_o;
  logic [3:0] h_io_oe;
  logic [3:0] d_io_o;
  logic [3:0] d_io_oe;
  logic [3:0] io;

  assign io = (h_io_oe & h_io_o) | (~h_io_oe & d_io_oe & d_io_o) | (~h_io_oe & ~d_io_oe);

  modport host (output cs_n, output sck, output h_io_o, output h_io_oe, input io);
  modport dev (input cs_n, input sck, input io, output d_io_o, output d_io_oe);
endinterface // sfwc_if

//--- sfwc_dev.sv
// Summary of operation
// - write disable clears write enable latch
// - latch low blocks program, erase, register writes
// - write disable ignored while write in progress
// - write disable needs chip select after bit eight
// - volatile enable needs chip select after bit eight
// - quad mode moves four bits per clock
// - volatile enable only steers next register write
// - clear status zeroes busy, latch, both errors
// - clear status needs no write enable
// - clear status accepted while busy
// - nv pattern program needs latch set
// - nv program ends exactly after data byte
// - nv program self-timed, busy until done
// - program failure sets error; latch cleared after
// - host keeps serial clock within maximum rate
// - volatile pattern write needs latch set
// - volatile pattern write immediate, one byte
// - pattern read: opcode, one dummy, byte out
// - dummy cycle data lines ignored
// - pattern repeats every eight further clocks in single mode, every two in quad mode
// - quad pattern read uses all four lines
// - write enable sets the latch
//
// Purpose: flash-side decoder for latch, status and learning-pattern commands
// Assumes: spi mode 0; link pins are asynchronous to clock
// Notes: the link is oversampled, so sck must stay well below clock / 6
//
// The address map and register access over Avalon-MM were decided locally.
`timescale 1ns/1ps
`include "sfwc_params.svh"

module sfwc_dev #(
  parameter int NV_PROG_CYCLES = `SFWC_NV_PROG_CYC
) (
  input wire logic clock, // system clock
  input wire logic rst_n, // async reset, active low
  sfwc_if.dev link, // serial link
  input wire logic quad_peripheral_mode, // four-line transfers
  input wire logic prog_fail, // nv program outcome, sampled at completion
  input wire logic erase_fail, // pulse: external erase reported an error
  output logic [7:0] volatile_status_one, // status one image
  output logic [7:0] volatile_status_two, // status two image
  output logic [7:0] learning_pattern_byte, // volatile pattern
  output logic [7:0] nv_pattern_byte, // stored pattern copy
  output logic volatile_target, // next register write goes volatile
  output logic write_permit // program/erase/register writes allowed
);

  // synchronisers; first stages are read only by second stages
  logic cs_s1_q, cs_s2_q, cs_s3_q;
  logic sck_s1_q, sck_s2_q, sck_s3_q;
  logic [3:0] io_s1_q, io_s2_q;

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cs_s1_q <= 1'b1;
      cs_s2_q <= 1'b1;
      cs_s3_q <= 1'b1;
      sck_s1_q <= 1'b0;
      sck_s2_q <= 1'b0;
      sck_s3_q <= 1'b0;
      io_s1_q <= 4'hf;
      io_s2_q <= 4'hf;
    end
    else
    begin
      cs_s1_q <= link.cs_n;
      cs_s2_q <= cs_s1_q;
      cs_s3_q <= cs_s2_q;
      sck_s1_q <= link.sck;
      sck_s2_q <= sck_s1_q;
      sck_s3_q <= sck_s2_q;
      io_s1_q <= link.io;
      io_s2_q <= io_s1_q;
    end
  end

  wire cs_low = ~cs_s2_q;
  wire cs_rise = cs_s2_q & ~cs_s3_q;
  wire sck_rise = cs_low & sck_s2_q & ~sck_s3_q;
  wire sck_fall = cs_low & ~sck_s2_q & sck_s3_q;

  function automatic logic [5:0] sat_add(input logic [5:0] a, input logic [5:0] b);
    logic [6:0] s;
    s = {1'b0, a} + {1'b0, b};
    return s[6] ? 6'h3f : s[5:0];
  endfunction

  // input shifting
  logic [15:0] sh_q;
  logic [5:0] bits_q;
  logic [5:0] clks_q;
  logic [7:0] op_q;
  wire [5:0] step = quad_peripheral_mode ? 6'h04 : 6'h01;
  wire [15:0] sh_d = quad_peripheral_mode ? {sh_q[11:0], io_s2_q} : {sh_q[14:0], io_s2_q[0]};
  wire [5:0] bits_d = sat_add(bits_q, step);

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sh_q <= 16'h0000;
      bits_q <= 6'h00;
      clks_q <= 6'h00;
      op_q <= 8'h00;
    end
    else if (!cs_low)
    begin
      bits_q <= 6'h00;
      clks_q <= 6'h00;
      op_q <= 8'h00;
    end
    else if (sck_rise)
    begin
      sh_q <= sh_d;
      bits_q <= bits_d;
      clks_q <= sat_add(clks_q, 6'h01);
      if (bits_d == 6'h08)
        op_q <= sh_d[7:0];
    end
  end

  // command decode at chip select release
  wire len_op = bits_q == 6'h08;
  wire len_data = bits_q == 6'h10;
  wire [7:0] data_byte = sh_q[7:0];
  logic wip_q, wel_q, perr_q, eerr_q, vtgt_q;
  wire go_wen = cs_rise & len_op & (op_q == `SFWC_OP_WRITE_ENABLE) & ~wip_q;
  wire go_wdis = cs_rise & len_op & (op_q == `SFWC_OP_WRITE_DISABLE) & ~wip_q;
  wire go_vwen = cs_rise & len_op & (op_q == `SFWC_OP_VOL_WRITE_ENABLE) & ~wip_q;
  wire go_clr = cs_rise & len_op & (op_q == `SFWC_OP_CLEAR_STATUS);
  wire go_nvp = cs_rise & len_data & (op_q == `SFWC_OP_NV_PAT_PROG) & wel_q & ~wip_q;
  wire go_vpw = cs_rise & len_data & (op_q == `SFWC_OP_VOL_PAT_WRITE) & wel_q & ~wip_q;
  wire any_cmd = cs_rise & (bits_q != 6'h00);

  sfwc_pkg::sfwc_dev_st_t st_q;
  logic [31:0] tmr_q;
  wire prog_done = (st_q == sfwc_pkg::SFWC_D_PROG) & (tmr_q == 32'(NV_PROG_CYCLES - 1));

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_q <= sfwc_pkg::SFWC_D_IDLE;
      tmr_q <= 32'h0;
    end
    else
    begin
      case (st_q)
        sfwc_pkg::SFWC_D_IDLE:
        begin
          tmr_q <= 32'h0;
          if (go_nvp)
            st_q <= sfwc_pkg::SFWC_D_PROG;
        end
        sfwc_pkg::SFWC_D_PROG:
        begin
          tmr_q <= tmr_q + 32'h1;
          if (prog_done || go_clr)
            st_q <= sfwc_pkg::SFWC_D_IDLE;
        end
        default:
          st_q <= sfwc_pkg::SFWC_D_IDLE;
      endcase
    end
  end

  // status bits; later assignments win, so hardware sets beat clears
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wip_q <= 1'b0;
      wel_q <= 1'b0;
      perr_q <= 1'b0;
      eerr_q <= 1'b0;
    end
    else
    begin
      if (go_clr)
      begin
        wip_q <= 1'b0;
        wel_q <= 1'b0;
        perr_q <= 1'b0;
        eerr_q <= 1'b0;
      end
      if (go_wen)
        wel_q <= 1'b1;
      if (go_wdis)
        wel_q <= 1'b0;
      if (go_nvp)
        wip_q <= 1'b1;
      if (prog_done)
      begin
        wel_q <= 1'b0;
        wip_q <= prog_fail;
        if (prog_fail)
          perr_q <= 1'b1;
      end
      // an error keeps the part busy until cleared
      if (erase_fail)
      begin
        eerr_q <= 1'b1;
        wip_q <= 1'b1;
      end
    end
  end

  // volatile steering and pattern copies
  logic [7:0] vpat_q, nvpat_q;
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      vtgt_q <= 1'b0;
      vpat_q <= `SFWC_PAT_RESET;
      nvpat_q <= `SFWC_PAT_RESET;
    end
    else
    begin
      if (go_vwen)
        vtgt_q <= 1'b1;
      else if (any_cmd)
        vtgt_q <= 1'b0;
      if (go_vpw)
        vpat_q <= data_byte;
      if (go_nvp)
        nvpat_q <= data_byte;
    end
  end

  // pattern readout: opcode clocks, one ignored dummy clock, then data
  wire [5:0] opc_clks = quad_peripheral_mode ? 6'h02 : 6'h08;
  wire rd_cmd = (op_q == `SFWC_OP_PAT_READ) & (bits_q >= 6'h08);
  wire rd_shift = sck_fall & rd_cmd & (clks_q > opc_clks);
  logic [2:0] pos_q;
  logic [3:0] dout_q, doe_q;
  wire [2:0] bit_sel = 3'h7 - pos_q;

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pos_q <= 3'h0;
      dout_q <= 4'h0;
      doe_q <= 4'h0;
    end
    else if (!cs_low)
    begin
      pos_q <= 3'h0;
      doe_q <= 4'h0;
    end
    else if (rd_shift)
    begin
      pos_q <= pos_q + 3'h1;
      if (quad_peripheral_mode)
      begin
        dout_q <= pos_q[0] ? vpat_q[3:0] : vpat_q[7:4];
        doe_q <= 4'hf;
      end
      else
      begin
        dout_q <= {2'b00, vpat_q[bit_sel], 1'b0};
        doe_q <= 4'h2;
      end
    end
  end

  assign link.d_io_o = dout_q;
  assign link.d_io_oe = doe_q;
  assign volatile_status_one = {6'h00, wel_q, wip_q};
  assign volatile_status_two = {1'b0, eerr_q, perr_q, 5'h00};
  assign learning_pattern_byte = vpat_q;
  assign nv_pattern_byte = nvpat_q;
  assign volatile_target = vtgt_q;
  assign write_permit = wel_q & ~wip_q;
endmodule // sfwc_dev

//--- sfwc_host.sv
// Purpose: controller end; issues one serial command per register write
// Assumes: avalon-mm slave with waitrequest; spi mode 0
// Notes: sck derived from clock; half period is a parameter
`timescale 1ns/1ps
`include "sfwc_params.svh"

module sfwc_host #(
  parameter int SCK_HALF = `SFWC_SCK_HALF_CYC
) (
  input wire logic clock, // system clock
  input wire logic rst_n, // async reset, active low
  input wire logic [3:0] address, // byte address
  input wire logic read, // read request
  input wire logic write, // write request
  input wire logic [31:0] writedata, // write data
  output logic [31:0] readdata, // read data
  output logic waitrequest, // stall
  sfwc_if.host link // serial link
);

  sfwc_pkg::sfwc_host_st_t st_q;
  logic [7:0] tmr_q;
  logic [15:0] tx_q;
  logic [7:0] rx_q;
  logic [5:0] ci_q, tot_q, drv_q;
  logic quad_q, rack_q;
  logic [31:0] rdat_q;
  logic [3:0] io_s1_q, io_s2_q;

  wire idle = st_q == sfwc_pkg::SFWC_H_IDLE;
  wire cmd_sel = address == `SFWC_REG_CMD;
  wire stat_sel = address == `SFWC_REG_STAT;
  wire accept = write & cmd_sel & idle;
  wire half_done = tmr_q == 8'(SCK_HALF - 1);
  wire wq = writedata[`SFWC_CMD_QUAD];
  wire wd = writedata[`SFWC_CMD_HAS_DATA];
  wire wr = writedata[`SFWC_CMD_READ];
  wire [5:0] byte_clks = wq ? 6'h02 : 6'h08;
  wire [5:0] drv_clks = wd ? 6'(2 * byte_clks) : byte_clks;
  wire [5:0] rd_clks = wr ? 6'(byte_clks + 6'h01) : 6'h00;
  wire [31:0] stat_word = {16'h0000, rx_q, 7'h00, ~idle};

  assign waitrequest = (write & cmd_sel & ~idle) | (read & ~rack_q);
  assign readdata = rdat_q;

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rack_q <= 1'b0;
      rdat_q <= 32'h0;
      io_s1_q <= 4'hf;
      io_s2_q <= 4'hf;
    end
    else
    begin
      rack_q <= read & ~rack_q;
      rdat_q <= (read & stat_sel) ? stat_word : 32'h0;
      io_s1_q <= link.io;
      io_s2_q <= io_s1_q;
    end
  end

  // one sck per low/high pair; data changes after falling; device samples at rising, host samples at end of high
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_q <= sfwc_pkg::SFWC_H_IDLE;
      tmr_q <= 8'h00;
      tx_q <= 16'h0000;
      rx_q <= 8'h00;
      ci_q <= 6'h00;
      tot_q <= 6'h00;
      drv_q <= 6'h00;
      quad_q <= 1'b0;
    end
    else
    begin
      tmr_q <= (idle || half_done) ? 8'h00 : tmr_q + 8'h01;
      case (st_q)
        sfwc_pkg::SFWC_H_IDLE:
          if (accept)
          begin
            tx_q <= {writedata[`SFWC_CMD_OP_LSB+7:`SFWC_CMD_OP_LSB],
                     writedata[`SFWC_CMD_DATA_LSB+7:`SFWC_CMD_DATA_LSB]};
            quad_q <= wq;
            drv_q <= drv_clks;
            tot_q <= 6'(drv_clks + rd_clks);
            ci_q <= 6'h00;
            st_q <= sfwc_pkg::SFWC_H_SETUP;
          end
        sfwc_pkg::SFWC_H_SETUP:
          if (half_done)
            st_q <= sfwc_pkg::SFWC_H_LOW;
        sfwc_pkg::SFWC_H_LOW:
          if (half_done)
            st_q <= sfwc_pkg::SFWC_H_HIGH;
        sfwc_pkg::SFWC_H_HIGH:
          if (half_done)
          begin
            // dummy clock at index drv_q is skipped; later clocks carry data
            if (ci_q > drv_q)
              rx_q <= quad_q ? {rx_q[3:0], io_s2_q} : {rx_q[6:0], io_s2_q[1]};
            tx_q <= quad_q ? {tx_q[11:0], 4'h0} : {tx_q[14:0], 1'b0};
            ci_q <= ci_q + 6'h01;
            // chip select rises one hold half period after the last clock falls
            st_q <= (ci_q + 6'h01 == tot_q) ? sfwc_pkg::SFWC_H_HOLD
                                            : sfwc_pkg::SFWC_H_LOW;
          end
        sfwc_pkg::SFWC_H_HOLD:
          if (half_done)
            st_q <= sfwc_pkg::SFWC_H_GAP;
        sfwc_pkg::SFWC_H_GAP:
          if (half_done)
            st_q <= sfwc_pkg::SFWC_H_IDLE;
        default:
          st_q <= sfwc_pkg::SFWC_H_IDLE;
      endcase
    end
  end

  wire driving = (ci_q < drv_q) & ((st_q == sfwc_pkg::SFWC_H_LOW) |
                                   (st_q == sfwc_pkg::SFWC_H_HIGH));
  assign link.cs_n = idle | (st_q == sfwc_pkg::SFWC_H_GAP);
  assign link.sck = st_q == sfwc_pkg::SFWC_H_HIGH;
  assign link.h_io_o = quad_q ? tx_q[15:12] : {3'b000, tx_q[15]};
  assign link.h_io_oe = driving ? (quad_q ? 4'hf : 4'h1) : 4'h0;
endmodule // sfwc_host

//--- sfwc_link_sva.sv
// Purpose: protocol checks on the serial link between the two ends
// Assumes: host built with SCK_HALF = 10, spi mode 0
// Notes: watches only the wires, so device internals are judged by the bench
`timescale 1ns/1ps
module sfwc_link_sva (
  input wire logic clock, // system clock
  input wire logic rst_n, // async reset, active low
  input wire logic cs_n, // chip select
  input wire logic sck, // serial clock
  input wire logic [3:0] h_io_o, // host data
  input wire logic [3:0] h_io_oe, // host enables
  input wire logic [3:0] d_io_o, // device data
  input wire logic [3:0] d_io_oe // device enables
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  sck_idle_a: assert property (cs_n |-> !sck)
    else $error("serial clock high while deselected");
  one_driver_a: assert property ((h_io_oe & d_io_oe) == 4'h0)
    else $error("host and device drive one line");
  dev_quiet_a: assert property ($rose(cs_n) |-> ##6 d_io_oe == 4'h0)
    else $error("device still drives after deselect");
  dev_lanes_a: assert property (d_io_oe inside {4'h0, 4'h2, 4'hf})
    else $error("device lane set illegal");
  host_lanes_a: assert property (h_io_oe inside {4'h0, 4'h1, 4'hf})
    else $error("host lane set illegal");
  cs_gap_a: assert property ($rose(cs_n) |-> cs_n [*8])
    else $error("deselect gap too short");
  cs_setup_a: assert property ($fell(cs_n) |-> !sck [*8])
    else $error("clock too soon after select");
  sck_high_a: assert property ($rose(sck) |-> sck [*8])
    else $error("serial clock high phase too short");
  host_hold_a: assert property (sck && $past(sck) |-> $stable(h_io_o))
    else $error("host data moved while clock high");
  dev_hold_a: assert property (sck && $past(sck) |-> $stable(d_io_o))
    else $error("device data moved while clock high");
endmodule // sfwc_link_sva

//--- test_sfwc.sv
// Purpose: end-to-end bench, controller registers to flash command logic
// Assumes: nv program shortened to NVC cycles
// Notes: integer model of status bits and pattern copies checked after each command
`timescale 1ns/1ps
`include "sfwc_params.svh"
module test_sfwc;
  localparam int NVC = 200;
  // {opcode, data byte present, pattern read}
  localparam logic [9:0] SEQ [0:12] = '{10'h018, 10'h140, 10'h018, 10'h12a, 10'h105,
    10'h012, 10'h142, 10'h010, 10'h12a, 10'h10e, 10'h018, 10'h10c, 10'h10e};
  logic clock, rst_n, read, write, qm, pf, ef, waitrequest, vto, wpo;
  logic [3:0] address;
  logic [31:0] writedata, readdata, q, lf;
  logic [7:0] s1, s2, lpo, npo;
  int err_count, cmp_count, cyc, write_enable_latch, write_in_progress, perr, eerr, vt, lp, np;
  sfwc_if lnk();
  sfwc_host #(.SCK_HALF(10)) sfwc_host_i (.clock(clock), .rst_n(rst_n),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest), .link(lnk));
  sfwc_dev #(.NV_PROG_CYCLES(NVC)) sfwc_dev_i (.clock(clock), .rst_n(rst_n), .link(lnk),
    .quad_peripheral_mode(qm), .prog_fail(pf), .erase_fail(ef), .volatile_status_one(s1),
    .volatile_status_two(s2), .learning_pattern_byte(lpo), .nv_pattern_byte(npo),
    .volatile_target(vto), .write_permit(wpo));
  sfwc_link_sva sfwc_link_sva_i (.clock(clock), .rst_n(rst_n), .cs_n(lnk.cs_n),
    .sck(lnk.sck), .h_io_o(lnk.h_io_o), .h_io_oe(lnk.h_io_oe), .d_io_o(lnk.d_io_o),
    .d_io_oe(lnk.d_io_oe));
  initial
  begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  function automatic logic [31:0] nxt(input logic [31:0] v);
    nxt = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  always @(posedge clock)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      err_count++;
      tally_and_finish();
    end
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e)
    begin
      err_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic chk_all();
    chk({24'h0, s1}, {30'h0, write_enable_latch[0], write_in_progress[0]});
    chk({24'h0, s2}, {25'h0, eerr[0], perr[0], 5'h0});
    chk({24'h0, lpo}, lp[7:0]);
    chk({24'h0, npo}, np[7:0]);
    chk({31'h0, vto}, vt[0]);
    chk({31'h0, wpo}, {31'h0, write_enable_latch[0] & !write_in_progress[0]});
  endtask
  // master holds the request until waitrequest is seen low at an edge
  task automatic av(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    write <= w;
    read <= !w;
    address <= a;
    writedata <= d;
    @(posedge clock);
    while (waitrequest) @(posedge clock);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask
  task automatic cmd(input logic [7:0] op, input logic [7:0] d, input bit hd, input bit rd);
    bit ok;
    av(1'b1, `SFWC_REG_CMD, {13'h0, qm, rd, hd, d, op});
    q = 32'h1;
    while (q[0]) av(1'b0, `SFWC_REG_STAT, 32'h0);
    repeat (8) @(posedge clock);
    ok = !write_in_progress && (hd == (op inside {8'h43, 8'h4a}));
    case (op)
      8'h06: if (ok) write_enable_latch = 1;
      8'h04: if (ok) write_enable_latch = 0;
      8'h30: if (!hd) {write_in_progress, write_enable_latch, perr, eerr} = '0;
      8'h4a: if (ok && write_enable_latch) lp = d;
      8'h43:
        if (ok && write_enable_latch)
        begin
          write_in_progress = 1;
          // stored copy is taken when the program starts
          np = d;
        end
      default: ;
    endcase
    vt = (op == 8'h50 && ok);
    if (rd)
    begin
      av(1'b0, `SFWC_REG_STAT, 32'h0);
      chk({24'h0, q[15:8]}, lp[7:0]);
      // the last falling clock restarts the byte, leaving its first group on the lines
      chk({28'h0, lnk.d_io_o}, qm ? {28'h0, lp[7:4]} : {30'h0, lp[7], 1'b0});
    end
    chk_all();
  endtask
  task automatic nvdone(input bit fail);
    repeat (NVC) @(posedge clock);
    write_enable_latch = 0;
    write_in_progress = fail;
    perr = fail;
    chk_all();
  endtask
  task automatic erase();
    @(posedge clock);
    ef <= 1'b1;
    @(posedge clock);
    ef <= 1'b0;
    repeat (4) @(posedge clock);
    write_in_progress = 1;
    eerr = 1;
    chk_all();
  endtask
  initial
  begin
    {rst_n, read, write, qm, pf, ef} = '0;
    address = 4'h0;
    writedata = 32'h0;
    lf = 32'h0831;
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    repeat (4) @(posedge clock);
    chk_all();
    av(1'b0, 4'h8, 32'h0);
    chk(q, 32'h0);
    for (int m = 0; m < 2; m++)
    begin
      qm <= m[0];
      // let the new mode settle before it is copied into the first command word
      @(posedge clock);
      foreach (SEQ[i])
      begin
        lf = nxt(lf);
        cmd(SEQ[i][9:2], lf[7:0], SEQ[i][1], SEQ[i][0]);
      end
      nvdone(1'b0);
    end
    // failed program keeps the part busy until clear status
    cmd(8'h06, 8'h00, 0, 0);
    pf <= 1'b1;
    cmd(8'h43, np[7:0], 1, 0);
    nvdone(1'b1);
    pf <= 1'b0;
    cmd(8'h04, 8'h00, 0, 0);
    cmd(8'h06, 8'h00, 0, 0);
    erase();
    cmd(8'h30, 8'h00, 0, 0);
    cmd(8'h06, 8'h00, 0, 0);
    erase();
    cmd(8'h04, 8'h00, 0, 0);
    cmd(8'h30, 8'h00, 0, 0);
    tally_and_finish();
  end
endmodule // test_sfwc
